/* bb_source.sv */
// Baseband sample source: holds each sample until the datapath takes it.
// Assumes valid and ready are sampled on the rising clock edge.
`timescale 1ns/1ps
module bb_source (
   // Clock, reset and control
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic run_i,
   // Sample handshake
   input wire logic ready_i,
   output logic valid_o = 1'b0,
   output logic [15:0] i_o = 16'h0000,
   output logic [15:0] q_o = 16'h0000
);
   int seed = 40;
   logic [31:0] r, d;
   always @(posedge clk_i) begin
      r = $random(seed);
      d = $random(seed);
      if (valid_o && !ready_i && !rst_i) begin
         valid_o <= #1 1'b1;
      end else if (run_i && !rst_i && r[1:0] != 2'h0) begin
         valid_o <= #1 1'b1;
         // Zero on one channel exercises single-channel complex input.
         i_o <= #1 (r[4:2] == 3'h0) ? 16'h0000 : (r[4:2] == 3'h1) ? 16'h8000 : d[15:0];
         q_o <= #1 (r[7:5] == 3'h0) ? 16'h0000 : (r[7:5] == 3'h1) ? 16'h8000 : d[31:16];
      end else begin
         // Idle lines toggle so stale data is never mistaken for a sample.
         valid_o <= #1 1'b0;
         i_o <= #1 ~i_o;
         q_o <= #1 ~q_o;
      end
   end
endmodule : bb_source

/* carrier_lut.sv */
// Carrier lookup: cosine and sine weights for the selected modulation rate.
// Assumes the caller advances the phase once per modulated sample.
`timescale 1ns/1ps
module carrier_lut (
   // Selection
   input wire logic [1:0] mod_sel_i,
   input wire logic [2:0] phase_i,
   // Carrier weights
   output logic signed [mix_stuff_pkg::COEF_W-1:0] cos_o,
   output logic signed [mix_stuff_pkg::COEF_W-1:0] sin_o
);
   import mix_stuff_pkg::*;

   // Eight-step sine, indexed by phase; cosine is the same table shifted a quarter turn.
   function automatic logic signed [COEF_W-1:0] sine8(input logic [2:0] p);
      unique case (p)
         3'h0: sine8 = '0;
         3'h1: sine8 = COEF_ROOT_HALF;
         3'h2: sine8 = COEF_ONE;
         3'h3: sine8 = COEF_ROOT_HALF;
         3'h4: sine8 = '0;
         3'h5: sine8 = -COEF_ROOT_HALF;
         3'h6: sine8 = -COEF_ONE;
         3'h7: sine8 = -COEF_ROOT_HALF;
      endcase
   endfunction : sine8

   always_comb begin
      cos_o = COEF_ONE;
      sin_o = '0;
      unique case (mod_sel_i)
         MOD_NONE: begin
            cos_o = COEF_ONE;
            sin_o = '0;
         end
         MOD_HALF: begin
            // A half-rate carrier has no quadrature partner: sine stays zero.
            cos_o = phase_i[0] ? -COEF_ONE : COEF_ONE;
            sin_o = '0;
         end
         MOD_QUARTER: begin
            sin_o = sine8({phase_i[1:0], 1'b0});
            cos_o = sine8({phase_i[1:0], 1'b0} + 3'h2);
         end
         MOD_EIGHTH: begin
            sin_o = sine8(phase_i);
            cos_o = sine8(phase_i + 3'h2);
         end
      endcase
   end

endmodule : carrier_lut

/* complex_mix_zero_stuff_datapath.sv */
// Final transmit stage ahead of the converter: real or complex digital modulation,
// then optional midscale stuffing. Runs on the DAC sample clock.
// Assumes the serial-port logic and the interpolation output share clk_i.
//
// Contract
// - Zero stuffing is active only while mode bit 3 is one.
// - When stuffing, every data sample is followed by one midscale code 8000h.
// - Stuffing doubles converter rate against the data rate.
// - Stuffing happens after the modulator, immediately before the converter outputs.
// - Mode bit 2 couples both modulators into one complex modulator.
// - Mode bit 1 picks positive or negative complex rotation.
// - Complex mode uses the same half, quarter, eighth rate carriers.
// - At quarter and eighth rate, complex outputs are valid with data on I only, Q only or both.
// - Mode bits 5 and 4 select the modulation frequency.
// - Mode bits 7 and 6 select interpolation 1x, 2x, 4x or 8x.
// - Quarter-rate modulation multiplies samples by 0, +1, 0, -1 in turn.
`timescale 1ns/1ps
module complex_mix_zero_stuff_datapath (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Control register port from the serial interface
   input wire logic reg_wr_i,
   input wire logic [mix_stuff_pkg::ADDR_W-1:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   // Interpolated samples in, twos complement
   input wire logic in_valid_i,
   input wire logic [mix_stuff_pkg::DATA_W-1:0] in_i_data_i,
   input wire logic [mix_stuff_pkg::DATA_W-1:0] in_q_data_i,
   output logic in_ready_o,
   // Converter samples out, offset binary
   output logic dac_valid_o,
   output logic [mix_stuff_pkg::DATA_W-1:0] dac_i_o,
   output logic [mix_stuff_pkg::DATA_W-1:0] dac_q_o,
   // Rate settings for the filters and clock multiplier
   output logic [1:0] interp_sel_o,
   output logic [mix_stuff_pkg::RATIO_W-1:0] clk_ratio_o
);
   import mix_stuff_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Arithmetic helpers.

   function automatic logic signed [COEF_W:0] scale(input logic signed [DATA_W-1:0] d,
                                                    input logic signed [COEF_W-1:0] c);
      logic signed [DATA_W+COEF_W-1:0] prod;
      prod = d * c;
      scale = {prod[DATA_W+COEF_W-1], prod[DATA_W+COEF_W-1:COEF_FRAC]};
   endfunction : scale

   // Saturates and converts to offset binary by flipping the sign bit.
   function automatic logic [DATA_W-1:0] to_dac(input logic signed [COEF_W:0] v);
      logic signed [DATA_W-1:0] s;
      if (v > (COEF_W+1)'(SAT_MAX))
         s = SAT_MAX;
      else if (v < $signed({{(COEF_W+1-DATA_W){1'b1}}, SAT_MIN}))
         s = SAT_MIN;
      else
         s = v[DATA_W-1:0];
      to_dac = {~s[DATA_W-1], s[DATA_W-2:0]};
   endfunction : to_dac

   ////////////////////////////////////////////////////////////////////////////
   // Mode control register.

   logic [7:0] mode_reg, mode_next;
   logic [7:0] rdata_reg, rdata_next;
   logic [1:0] interp_reg, interp_next;
   logic [RATIO_W-1:0] ratio_reg, ratio_next;

   logic stuff_en, cplx_en, rot_pos;
   logic [1:0] mod_sel;

   assign stuff_en = mode_reg[STUFF_EN_BIT];
   assign cplx_en = mode_reg[CPLX_EN_BIT];
   assign rot_pos = mode_reg[ROT_POS_BIT];
   assign mod_sel = mode_reg[MODSEL_HI_BIT:MODSEL_LO_BIT];

   always_comb begin
      mode_next = mode_reg;
      if (reg_wr_i && reg_addr_i == MODE_CTRL_ADDR)
         mode_next = reg_wdata_i;
      rdata_next = (reg_addr_i == MODE_CTRL_ADDR) ? mode_reg : 8'h00;
      interp_next = mode_reg[INTERP_HI_BIT:INTERP_LO_BIT];
      // Converter-to-data ratio: interpolation factor, doubled by stuffing.
      // The shift amount is three bits wide so that 8x with stuffing reaches sixteen.
      ratio_next = RATIO_UNIT << ({1'b0, interp_next} + {2'b00, stuff_en});
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_reg <= MODE_CTRL_RESET;
         rdata_reg <= 8'h00;
         interp_reg <= 2'h0;
         ratio_reg <= RATIO_UNIT;
      end else begin
         mode_reg <= mode_next;
         rdata_reg <= rdata_next;
         interp_reg <= interp_next;
         ratio_reg <= ratio_next;
      end
   end

   assign reg_rdata_o = rdata_reg;
   assign interp_sel_o = interp_reg;
   assign clk_ratio_o = ratio_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Modulator.

   logic [2:0] phase_reg, phase_next;
   logic signed [COEF_W-1:0] cos_w, sin_w;
   logic signed [COEF_W-1:0] sin_rot;
   logic signed [DATA_W-1:0] in_i, in_q;
   logic signed [COEF_W:0] ic, qc, is_t, qs_t;
   logic signed [COEF_W:0] mod_i, mod_q;
   logic accept;

   carrier_lut u_carrier (
      .mod_sel_i(mod_sel),
      .phase_i(phase_reg),
      .cos_o(cos_w),
      .sin_o(sin_w)
   );

   assign in_i = $signed(in_i_data_i);
   assign in_q = $signed(in_q_data_i);
   assign accept = in_valid_i && in_ready_o;

   always_comb begin
      phase_next = phase_reg;
      if (accept)
         phase_next = phase_reg + 3'h1;
      // Negative rotation only flips the sine terms.
      sin_rot = rot_pos ? sin_w : -sin_w;
      ic = scale(in_i, cos_w);
      qc = scale(in_q, cos_w);
      is_t = scale(in_i, sin_rot);
      qs_t = scale(in_q, sin_rot);
      if (cplx_en) begin
         // At quarter and eighth rate each channel draws on both inputs, so one idle input still yields a full pair.
         mod_i = ic - qs_t;
         mod_q = is_t + qc;
      end else if (mod_sel == MOD_QUARTER || mod_sel == MOD_EIGHTH) begin
         // Real mode rides on the sine carrier, giving 0, +1, 0, -1 at quarter rate.
         mod_i = scale(in_i, sin_w);
         mod_q = scale(in_q, sin_w);
      end else begin
         mod_i = ic;
         mod_q = qc;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i)
         phase_reg <= 3'h0;
      else
         phase_reg <= phase_next;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Zero stuffing at the converter edge.

   logic ready_reg, ready_next;
   logic valid_reg, valid_next;
   logic [DATA_W-1:0] dac_i_reg, dac_i_next;
   logic [DATA_W-1:0] dac_q_reg, dac_q_next;

   always_comb begin
      // A stuffed slot follows each accepted sample, so input is refused for one cycle.
      ready_next = !(stuff_en && accept);
      valid_next = 1'b0;
      dac_i_next = MIDSCALE_CODE;
      dac_q_next = MIDSCALE_CODE;
      if (accept) begin
         valid_next = 1'b1;
         dac_i_next = to_dac(mod_i);
         dac_q_next = to_dac(mod_q);
      end else if (!ready_reg) begin
         valid_next = 1'b1;
         dac_i_next = MIDSCALE_CODE;
         dac_q_next = MIDSCALE_CODE;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ready_reg <= 1'b1;
         valid_reg <= 1'b0;
         dac_i_reg <= MIDSCALE_CODE;
         dac_q_reg <= MIDSCALE_CODE;
      end else begin
         ready_reg <= ready_next;
         valid_reg <= valid_next;
         dac_i_reg <= dac_i_next;
         dac_q_reg <= dac_q_next;
      end
   end

   assign in_ready_o = ready_reg;
   assign dac_valid_o = valid_reg;
   assign dac_i_o = dac_i_reg;
   assign dac_q_o = dac_q_reg;

endmodule : complex_mix_zero_stuff_datapath

/* complex_mix_zero_stuff_datapath_test.sv */
// Self-checking bench for the mix and zero-stuff datapath.
// Assumes the checker is bound in and the source model feeds the input.
`timescale 1ns/1ps
module complex_mix_zero_stuff_datapath_test;
   import mix_stuff_pkg::*;
   logic clk_i, rst_i, reg_wr_i, in_valid_i, in_ready_o, dac_valid_o, run, hit, rs;
   logic [ADDR_W-1:0] reg_addr_i;
   logic [7:0] reg_wdata_i, reg_rdata_o, mode, m;
   logic [DATA_W-1:0] in_i_data_i, in_q_data_i, dac_i_o, dac_q_o, ei, eq;
   logic [1:0] interp_sel_o;
   logic [RATIO_W-1:0] clk_ratio_o;
   logic [2:0] ph = 3'h0;
   logic sp = 1'b0;
   logic [31:0] r;
   int seed = 40;
   int mismatches = 0;
   int num_checks = 0;
   int cycles = 0;
   complex_mix_zero_stuff_datapath i_complex_mix_zero_stuff_datapath (
      .clk_i(clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .in_valid_i(in_valid_i),
      .in_i_data_i(in_i_data_i), .in_q_data_i(in_q_data_i), .in_ready_o(in_ready_o),
      .dac_valid_o(dac_valid_o), .dac_i_o(dac_i_o), .dac_q_o(dac_q_o),
      .interp_sel_o(interp_sel_o), .clk_ratio_o(clk_ratio_o));
   bb_source i_bb_source (.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .ready_i(in_ready_o),
      .valid_o(in_valid_i), .i_o(in_i_data_i), .q_o(in_q_data_i));
   task automatic check(input string what, input logic [63:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic finish_test();
      if (mismatches == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : finish_test
   task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge clk_i);
      #1;
      reg_wr_i = 1'b1;
      reg_addr_i = a;
      reg_wdata_i = d;
      if (a == MODE_CTRL_ADDR) mode = d;
      @(posedge clk_i);
      #1;
      reg_wr_i = 1'b0;
   endtask : reg_write
   task automatic reg_read(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
      reg_addr_i = a;
      @(posedge clk_i);
      #1;
      check("reg_rdata", reg_rdata_o, exp);
   endtask : reg_read
   task automatic reset_check();
      check("idle", {dac_valid_o, in_ready_o, dac_i_o, dac_q_o}, {2'h1, 32'h80008000});
      check("ratio", clk_ratio_o, 5'h01);
      reg_read(MODE_CTRL_ADDR, MODE_CTRL_RESET);
   endtask : reset_check
   function automatic logic [15:0] sat(input int v);
      int w = (v > 32767) ? 32767 : (v < -32768) ? -32768 : v;
      return {~w[15], w[14:0]};
   endfunction : sat
   function automatic logic [31:0] expect_out(input logic [15:0] di, dq, input logic [7:0] x,
                                             input logic [2:0] p);
      logic [1:0] n = (x[5:4] == MOD_EIGHTH) ? p[2:1] : p[1:0];
      int s = (n == 2'h1) ? 1 : (n == 2'h3) ? -1 : 0;
      int c = (n == 2'h0) ? 1 : (n == 2'h2) ? -1 : 0;
      int g = x[ROT_POS_BIT] ? 1 : -1;
      if (!x[5]) s = 0;
      if (!x[5]) c = (x[5:4] == MOD_HALF && p[0]) ? -1 : 1;
      if (!x[CPLX_EN_BIT]) g = 0;
      if (!x[CPLX_EN_BIT] && x[5]) c = s;
      return {sat($signed(di) * c - g * $signed(dq) * s), sat(g * $signed(di) * s + $signed(dq) * c)};
   endfunction : expect_out
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   // Outputs are compared 2 ns after the edge so that registered values have landed.
   always @(posedge clk_i) begin
      hit = in_valid_i && in_ready_o && !rst_i;
      rs = rst_i;
      ei = in_i_data_i;
      eq = in_q_data_i;
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         finish_test();
      end
      #2;
      // With stuffing on, the cycle after an accepted sample's data output must carry the midscale slot.
      if (sp && !rs)
         check("stuffed", {dac_valid_o, dac_i_o, dac_q_o}, {1'b1, 32'h80008000});
      sp = hit && mode[STUFF_EN_BIT];
      if (rs) ph = 3'h0;
      else if (hit) begin
         check("dac_valid", dac_valid_o, 1'b1);
         check("in_ready", in_ready_o, !mode[STUFF_EN_BIT]);
         // Eighth-rate odd phases carry irrational weights, so only even phases are compared.
         if (!(mode[5:4] == MOD_EIGHTH && ph[0]))
            check("dac_out", {dac_i_o, dac_q_o}, expect_out(ei, eq, mode, ph));
         ph = ph + 3'h1;
      end
   end
   initial begin
      rst_i = 1'b1;
      {reg_wr_i, reg_addr_i, reg_wdata_i, run, mode} = '0;
      repeat (4) @(posedge clk_i);
      #1;
      rst_i = 1'b0;
      reset_check();
      for (int k = 0; k < 32; k++) begin
         r = $random(seed);
         m = {r[1:0], k[1:0], k[2], k[3], k[4], 1'b0};
         reg_write(MODE_CTRL_ADDR, m);
         reg_write({k[3:0], 1'b0}, ~m);
         reg_read(MODE_CTRL_ADDR, m);
         check("interp", interp_sel_o, m[7:6]);
         check("ratio", clk_ratio_o, RATIO_UNIT << ({1'b0, m[7:6]} + m[3]));
         reg_read({k[3:0], 1'b0}, 8'h00);
         run = 1'b1;
         repeat (40) @(posedge clk_i);
         #1;
         run = 1'b0;
         repeat (4) @(posedge clk_i);
      end
      run = 1'b1;
      repeat (10) @(posedge clk_i);
      #1;
      rst_i = 1'b1;
      @(posedge clk_i);
      #1;
      rst_i = 1'b0;
      mode = 8'h00;
      reset_check();
      repeat (10) @(posedge clk_i);
      finish_test();
   end
endmodule : complex_mix_zero_stuff_datapath_test

/* mix_stuff_assertions.sv */
// Checker for the mix and zero-stuff datapath, bound to its top module.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
module mix_stuff_checker import mix_stuff_pkg::*; (
   // Clock, reset and register port
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic reg_wr_i,
   input wire logic [ADDR_W-1:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_rdata_o,
   // Streams and rates
   input wire logic in_valid_i,
   input wire logic in_ready_o,
   input wire logic dac_valid_o,
   input wire logic [DATA_W-1:0] dac_i_o,
   input wire logic [DATA_W-1:0] dac_q_o,
   input wire logic [1:0] interp_sel_o,
   input wire logic [RATIO_W-1:0] clk_ratio_o
);
   logic [7:0] mode_reg, mode_next;
   logic wr, acc;
   assign wr = reg_wr_i && reg_addr_i == MODE_CTRL_ADDR;
   assign acc = in_valid_i && in_ready_o;
   always_comb mode_next = wr ? reg_wdata_i : mode_reg;
   always_ff @(posedge clk_i) mode_reg <= rst_i ? MODE_CTRL_RESET : mode_next;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_acc; acc && mode_reg[STUFF_EN_BIT]; endsequence
   sequence s_mid; dac_i_o == MIDSCALE_CODE && dac_q_o == MIDSCALE_CODE; endsequence
   // The data sample leaves one edge after the accept; the midscale slot follows it.
   property p_slot; s_acc |-> ##2 s_mid ##0 dac_valid_o; endproperty
   a_slot: assert property (p_slot) else $error("no midscale slot");
   property p_rate; s_acc |=> !in_ready_o ##1 in_ready_o; endproperty
   a_rate: assert property (p_rate) else $error("stuff rate");
   property p_bypass; !mode_reg[STUFF_EN_BIT] [*2] |-> in_ready_o; endproperty
   a_bypass: assert property (p_bypass) else $error("ready dropped");
   property p_acc; acc |=> dac_valid_o; endproperty
   a_acc: assert property (p_acc) else $error("no output");
   property p_idle; in_ready_o && !in_valid_i |=> !dac_valid_o ##0 s_mid; endproperty
   a_idle: assert property (p_idle) else $error("idle output");
   property p_intp; wr |-> ##2 interp_sel_o == $past(reg_wdata_i[7:6], 2); endproperty
   a_intp: assert property (p_intp) else $error("interp select");
   property p_ratio; wr |-> ##2 clk_ratio_o == RATIO_UNIT <<
      ({1'b0, $past(reg_wdata_i[7:6], 2)} + $past(reg_wdata_i[3], 2)); endproperty
   a_ratio: assert property (p_ratio) else $error("clock ratio");
   property p_rd; reg_addr_i == MODE_CTRL_ADDR |=> reg_rdata_o == $past(mode_reg); endproperty
   a_rd: assert property (p_rd) else $error("mode read");
   property p_unmap; reg_addr_i != MODE_CTRL_ADDR |=> reg_rdata_o == 8'h00; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read");
endmodule : mix_stuff_checker
bind complex_mix_zero_stuff_datapath mix_stuff_checker i_mix_stuff_checker (
   .clk_i(clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .in_valid_i(in_valid_i),
   .in_ready_o(in_ready_o), .dac_valid_o(dac_valid_o), .dac_i_o(dac_i_o),
   .dac_q_o(dac_q_o), .interp_sel_o(interp_sel_o), .clk_ratio_o(clk_ratio_o));

/* mix_stuff_pkg.sv */
// Constants shared by the transmit mix and zero-stuff datapath.
// Assumes one DAC sample clock domain for all users of this package.
package mix_stuff_pkg;

   // Register access.
   localparam int ADDR_W = 5;
   localparam logic [ADDR_W-1:0] MODE_CTRL_ADDR = 5'h01;
   localparam logic [7:0] MODE_CTRL_RESET = 8'h00;

   // Field positions in the mode control register.
   localparam int INTERP_HI_BIT = 7;
   localparam int INTERP_LO_BIT = 6;
   localparam int MODSEL_HI_BIT = 5;
   localparam int MODSEL_LO_BIT = 4;
   localparam int STUFF_EN_BIT = 3;
   localparam int CPLX_EN_BIT = 2;
   localparam int ROT_POS_BIT = 1;

   // Modulation selections.
   localparam logic [1:0] MOD_NONE = 2'h0;
   localparam logic [1:0] MOD_HALF = 2'h1;
   localparam logic [1:0] MOD_QUARTER = 2'h2;
   localparam logic [1:0] MOD_EIGHTH = 2'h3;

   // Data widths and codes.
   localparam int DATA_W = 16;
   localparam int COEF_W = 18;
   localparam int COEF_FRAC = 16;
   localparam logic [DATA_W-1:0] MIDSCALE_CODE = 16'h8000;
   localparam logic signed [COEF_W-1:0] COEF_ONE = 18'h10000;
   localparam logic signed [COEF_W-1:0] COEF_ROOT_HALF = 18'h0B505;
   localparam logic signed [DATA_W-1:0] SAT_MAX = 16'h7FFF;
   localparam logic signed [DATA_W-1:0] SAT_MIN = 16'h8000;

   // Clock ratio reporting.
   localparam int RATIO_W = 5;
   localparam logic [RATIO_W-1:0] RATIO_UNIT = 5'h01;

endpackage : mix_stuff_pkg
